//--- shared/lin_mode_pkg.sv
// constants, mode encoding and register map of the lin mode controller
// assumes one 125 MHz core clock and a 32-bit avalon-mm register port
package lin_mode_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ         = 125;
    localparam int WAKE_LOW_US     = 80;     // least bus-low time for a wake
    localparam int WAKE_LOW_CYCLES = WAKE_LOW_US * CLK_MHZ;
    localparam int WAKE_CNT_W      = 14;

    ////////////////////////////////////////////////////////////////////////
    // register bus
    localparam int          ADDR_W     = 4;
    localparam int          DATA_W     = 32;
    localparam logic [3:0]  CTRL_OFS   = 4'h0;
    localparam logic [3:0]  STATUS_OFS = 4'h4;

    // control: wake source enables
    localparam int          CTRL_W          = 2;
    localparam int          CTRL_RWAKE_BIT  = 0;
    localparam int          CTRL_LWAKE_BIT  = 1;
    localparam logic [1:0]  CTRL_RESET      = 2'h3;

    // status: mode, sticky wake sources (write one to clear), live levels
    localparam int          STAT_MODE_LSB   = 0;
    localparam int          STAT_RWAKE_BIT  = 5;
    localparam int          STAT_LWAKE_BIT  = 6;
    localparam int          STAT_REGOK_BIT  = 7;
    localparam int          STAT_FAULT_BIT  = 8;

    ////////////////////////////////////////////////////////////////////////
    // positions in the pin synchroniser vector
    localparam int SYN_W      = 9;
    localparam int SYN_OFF    = 0;   // supply above off threshold
    localparam int SYN_ON     = 1;   // supply above on threshold
    localparam int SYN_REGOK  = 2;
    localparam int SYN_CS     = 3;
    localparam int SYN_FTE    = 4;
    localparam int SYN_TXD    = 5;
    localparam int SYN_BUS    = 6;
    localparam int SYN_WAKE   = 7;   // bus below wake threshold
    localparam int SYN_FAULT  = 8;

    ////////////////////////////////////////////////////////////////////////
    // operating modes, one-hot
    typedef enum logic [4:0]
    {
        MODE_POR    = 5'b00001,
        MODE_READY  = 5'b00010,
        MODE_OPER   = 5'b00100,
        MODE_TXOFF  = 5'b01000,
        MODE_PDOWN  = 5'b10000
    } mode_t;

endpackage : lin_mode_pkg

//--- hw/bus_wake_filter.sv
// remote wake detector: a long low on the bus followed by a rising edge
// assumes bus_below is already synchronised to core_clk
`timescale 1ns/10ps
module bus_wake_filter
    import lin_mode_pkg::*;
#(
    parameter int LOW_CYCLES = WAKE_LOW_CYCLES
)
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    // detector
    input  wire logic armed,
    input  wire logic bus_below,
    output logic      wake_pulse
);

    localparam logic [WAKE_CNT_W-1:0] LIMIT = WAKE_CNT_W'(LOW_CYCLES);

    logic [WAKE_CNT_W-1:0] low_cnt_reg;
    logic [WAKE_CNT_W-1:0] low_cnt_next;
    logic                  below_prev_reg;
    logic                  wake_reg;
    logic                  wake_next;

    ////////////////////////////////////////////////////////////////////////
    // count the low phase, saturating so a long break still qualifies
    always_comb
    begin
        low_cnt_next = low_cnt_reg;
        wake_next    = 1'b0;
        if (!armed)
        begin
            low_cnt_next = '0;
        end
        else if (bus_below)
        begin
            if (low_cnt_reg != LIMIT)
            begin
                low_cnt_next = low_cnt_reg + 1'b1;
            end
        end
        else
        begin
            // rising edge ends the low phase: wake only if long enough
            wake_next    = below_prev_reg && (low_cnt_reg == LIMIT);
            low_cnt_next = '0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            low_cnt_reg    <= '0;
            below_prev_reg <= 1'b0;
            wake_reg       <= 1'b0;
        end
        else if (clk_en)
        begin
            low_cnt_reg    <= low_cnt_next;
            below_prev_reg <= bus_below && armed;
            wake_reg       <= wake_next;
        end
    end

    assign wake_pulse = wake_reg;

endmodule : bus_wake_filter

//--- hw/lin_transceiver_mode_control.sv
// mode controller of a lin transceiver with an avalon-mm register port
// assumes analog comparators deliver supply and bus levels as async pins
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps

// Notes on behaviour
// - low supply forces power-on-reset from anywhere
// - supply above on threshold leaves reset
// - ready: regulator low power, receiver on
// - ready holds until regulator good, select, enable and transmit data high
// - four conditions high enter operation mode
// - bus pull-up only in operation mode
// - select falling edge enters power-down from operation or transmitter-off
// - enable falling edge, select high: transmitter off
// - enable level low on pin low or fault
// - transmitter-off: receiver on, watchdog off
// - fault keeps transmitter off despite pin
// - unstable regulator always disables transmitter
// - power-down: only wake detectors stay alive
// - bus wake enters ready, then operation
// - select high wakes power-down into ready
// - power-down uses separate wake threshold
// - wake needs 80 us low, then rise
// - transmitter drives bus as transmit data
// - receive output follows bus when enabled
module lin_transceiver_mode_control
    import lin_mode_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_LOW_CYCLES
)
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    // supply and regulator comparators
    input  wire logic              battery_supply_above_off,
    input  wire logic              battery_supply_above_on,
    input  wire logic              regulator_good,
    input  wire logic              internal_fault,
    // host control pins
    input  wire logic              select_local_wake,
    input  wire logic              fault_tx_enable_in,
    output logic                   fault_tx_enable_out,
    output logic                   fault_tx_enable_oe,
    input  wire logic              tx_data,
    output logic                   rx_data,
    output logic                   reset_out,
    output logic                   reset_oe,
    // bus line
    input  wire logic              bus_line_in,
    input  wire logic              bus_below_wake,
    output logic                   bus_line_out,
    output logic                   bus_line_oe,
    output logic                   bus_pullup_on,
    output logic                   wake_detect_on,
    // regulator and front-end power
    output logic                   regulator_on,
    output logic                   regulator_low_power,
    output logic                   receiver_on,
    output logic                   window_watchdog_on,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [3:0]        byteenable,
    input  wire logic [DATA_W-1:0] writedata,
    output logic [DATA_W-1:0]      readdata,
    output logic                   waitrequest
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [SYN_W-1:0] sync1_reg;
    logic [SYN_W-1:0] sync2_reg;
    logic [SYN_W-1:0] sync_next;
    always_comb
    begin
        sync_next            = '0;
        sync_next[SYN_OFF]   = battery_supply_above_off;
        sync_next[SYN_ON]    = battery_supply_above_on;
        sync_next[SYN_REGOK] = regulator_good;
        sync_next[SYN_CS]    = select_local_wake;
        sync_next[SYN_FTE]   = fault_tx_enable_in;
        sync_next[SYN_TXD]   = tx_data;
        sync_next[SYN_BUS]   = bus_line_in;
        sync_next[SYN_WAKE]  = bus_below_wake;
        sync_next[SYN_FAULT] = internal_fault;
    end
    // first stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else if (clk_en)
        begin
            sync1_reg <= sync_next;
            sync2_reg <= sync1_reg;
        end
    end

    logic supply_ok;
    logic supply_on;
    logic reg_ok;
    logic cs_lvl;
    logic fault_lvl;
    logic txd_lvl;
    logic fte_lvl;
    assign supply_ok = sync2_reg[SYN_OFF];
    assign supply_on = sync2_reg[SYN_ON];
    assign reg_ok    = sync2_reg[SYN_REGOK];
    assign cs_lvl    = sync2_reg[SYN_CS];
    assign txd_lvl   = sync2_reg[SYN_TXD];
    assign fault_lvl = sync2_reg[SYN_FAULT];
    // pin high counts only with no internal fault
    assign fte_lvl   = sync2_reg[SYN_FTE] && !fault_lvl;

    ////////////////////////////////////////////////////////////////////////
    // edge detection on select and enable level
    logic cs_prev_reg;
    logic fte_prev_reg;
    logic cs_prev_next;
    logic fte_prev_next;
    logic cs_fall;
    logic fte_fall;
    always_comb
    begin
        cs_prev_next  = cs_lvl;
        fte_prev_next = fte_lvl;
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cs_prev_reg  <= 1'b0;
            fte_prev_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            cs_prev_reg  <= cs_prev_next;
            fte_prev_reg <= fte_prev_next;
        end
    end

    assign cs_fall  = cs_prev_reg && !cs_lvl;
    assign fte_fall = fte_prev_reg && !fte_lvl;

    ////////////////////////////////////////////////////////////////////////
    // remote wake detector, armed only in power-down
    mode_t          mode_reg;
    mode_t          mode_next;
    logic [CTRL_W-1:0] ctrl_reg;
    logic           remote_wake;
    bus_wake_filter #(.LOW_CYCLES(WAKE_CYCLES)) u_wake (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .clk_en     (clk_en),
        .armed      (mode_reg == MODE_PDOWN),
        .bus_below  (sync2_reg[SYN_WAKE]),
        .wake_pulse (remote_wake)
    );

    ////////////////////////////////////////////////////////////////////////
    // mode sequencer
    logic op_ok;
    logic rwake_go;
    logic lwake_go;
    assign op_ok    = reg_ok && cs_lvl && fte_lvl && txd_lvl;
    assign rwake_go = remote_wake && ctrl_reg[CTRL_RWAKE_BIT];
    assign lwake_go = cs_lvl && ctrl_reg[CTRL_LWAKE_BIT];
    always_comb
    begin
        mode_next = mode_reg;
        if (!supply_ok)
            mode_next = MODE_POR;
        else
            case (mode_reg)
                MODE_POR:
                    if (supply_on)
                        mode_next = MODE_READY;
                MODE_READY:
                    if (op_ok)
                        mode_next = MODE_OPER;
                MODE_TXOFF:
                    if (op_ok)
                        mode_next = MODE_OPER;
                    else if (cs_fall)
                        mode_next = MODE_PDOWN;
                MODE_OPER:
                    if (cs_fall)
                        mode_next = MODE_PDOWN;
                    else if (fte_fall && cs_lvl)
                        mode_next = MODE_TXOFF;
                // ready first; operation follows once regulator good, select, enable and transmit data are high
                MODE_PDOWN:
                    if (rwake_go)
                        mode_next = MODE_READY;
                    else if (lwake_go)
                        mode_next = MODE_READY;
                default:
                    mode_next = MODE_POR;
            endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // front-end controls, registered from the next mode
    logic rx_on_next;
    logic tx_on_next;
    logic reg_on_next;
    logic reg_lp_next;
    logic pullup_next;
    logic wdt_next;
    logic rxd_next;
    logic drive_next;
    logic rst_low_next;
    logic tx_on_reg;
    always_comb
    begin
        rx_on_next  = (mode_next == MODE_READY) ||
                      (mode_next == MODE_OPER)  ||
                      (mode_next == MODE_TXOFF);
        // regulator off in reset and power-down
        reg_on_next = rx_on_next;
        reg_lp_next = (mode_next == MODE_READY) ||
                      (mode_next == MODE_TXOFF);
        wdt_next    = (mode_next == MODE_OPER);
        pullup_next = (mode_next == MODE_OPER);
        // fault or shaky regulator always silences the driver
        tx_on_next  = (mode_next == MODE_OPER) && reg_ok &&
                      fte_lvl;
        drive_next  = tx_on_next && !txd_lvl;
        // recessive while the receiver is off
        rxd_next    = rx_on_next ? sync2_reg[SYN_BUS] : 1'b1;
        rst_low_next = (mode_next == MODE_POR) || !reg_ok;
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_reg            <= MODE_POR;
            receiver_on         <= 1'b0;
            regulator_on        <= 1'b0;
            regulator_low_power <= 1'b0;
            window_watchdog_on  <= 1'b0;
            bus_pullup_on       <= 1'b0;
            tx_on_reg           <= 1'b0;
            bus_line_oe         <= 1'b0;
            rx_data             <= 1'b1;
            reset_oe            <= 1'b1;
            wake_detect_on      <= 1'b0;
            fault_tx_enable_oe  <= 1'b0;
        end
        else if (clk_en)
        begin
            mode_reg            <= mode_next;
            receiver_on         <= rx_on_next;
            regulator_on        <= reg_on_next;
            regulator_low_power <= reg_lp_next;
            window_watchdog_on  <= wdt_next;
            bus_pullup_on       <= pullup_next;
            tx_on_reg           <= tx_on_next;
            bus_line_oe         <= drive_next;
            rx_data             <= rxd_next;
            reset_oe            <= rst_low_next;
            wake_detect_on      <= (mode_next == MODE_PDOWN);
            fault_tx_enable_oe  <= fault_lvl;
        end
    end

    // open-drain pins only ever pull low
    assign bus_line_out        = 1'b0;
    assign reset_out           = 1'b0;
    assign fault_tx_enable_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // avalon-mm slave: one wait cycle, then the access completes
    logic              wait_next;
    logic [DATA_W-1:0] rdata_next;
    logic [CTRL_W-1:0] ctrl_next;
    logic              rwake_flag_reg;
    logic              lwake_flag_reg;
    logic              rwake_flag_next;
    logic              lwake_flag_next;
    logic              wr_go;
    logic              clr_r;
    logic              clr_l;

    assign wr_go = write && !waitrequest;
    assign clr_r = wr_go && (address == STATUS_OFS) && byteenable[0] &&
                   writedata[STAT_RWAKE_BIT];
    assign clr_l = wr_go && (address == STATUS_OFS) && byteenable[0] &&
                   writedata[STAT_LWAKE_BIT];
    always_comb
    begin
        wait_next  = !(waitrequest && (read || write));
        rdata_next = '0;
        if (address == CTRL_OFS)
            rdata_next[CTRL_W-1:0] = ctrl_reg;
        else if (address == STATUS_OFS)
        begin
            rdata_next[STAT_MODE_LSB +: 5] = mode_reg;
            rdata_next[STAT_RWAKE_BIT]     = rwake_flag_reg;
            rdata_next[STAT_LWAKE_BIT]     = lwake_flag_reg;
            rdata_next[STAT_REGOK_BIT]     = reg_ok;
            rdata_next[STAT_FAULT_BIT]     = fault_lvl;
        end
        ctrl_next = ctrl_reg;
        if (wr_go && (address == CTRL_OFS) && byteenable[0])
            ctrl_next = writedata[CTRL_W-1:0];
        // a wake in the clearing cycle survives the clear
        rwake_flag_next = (rwake_flag_reg && !clr_r) ||
                          ((mode_reg == MODE_PDOWN) && rwake_go);
        lwake_flag_next = (lwake_flag_reg && !clr_l) ||
                          ((mode_reg == MODE_PDOWN) && !rwake_go &&
                           lwake_go);
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            waitrequest    <= 1'b1;
            readdata       <= '0;
            ctrl_reg       <= CTRL_RESET;
            rwake_flag_reg <= 1'b0;
            lwake_flag_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            waitrequest    <= wait_next;
            readdata       <= rdata_next;
            ctrl_reg       <= ctrl_next;
            rwake_flag_reg <= rwake_flag_next;
            lwake_flag_reg <= lwake_flag_next;
        end
    end

endmodule : lin_transceiver_mode_control

//--- test/lin_mode_chk.sv
// pin assertions for the lin mode controller
// assumes clk_en held high by the bench
`timescale 1ns/10ps
module lin_mode_chk
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // pins watched
    input wire logic battery_supply_above_off,
    input wire logic regulator_good,
    input wire logic internal_fault,
    input wire logic select_local_wake,
    input wire logic fault_tx_enable_in,
    input wire logic fault_tx_enable_oe,
    input wire logic tx_data,
    input wire logic rx_data,
    input wire logic reset_oe,
    input wire logic bus_line_in,
    input wire logic bus_line_oe,
    input wire logic bus_pullup_on,
    input wire logic wake_detect_on,
    input wire logic regulator_on,
    input wire logic receiver_on,
    input wire logic window_watchdog_on,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest
);
    logic [2:0] up_reg;
    logic [2:0] up_next;

    ////////////////////////////////////////////////////////////////////////
    // cycles since release, saturating
    always_comb
    begin
        up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            up_reg <= 3'h0;
        else
            up_reg <= up_next;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////
    chk_pullup_only_oper: assert property (
        bus_pullup_on == window_watchdog_on)
        else $error("pull-up mode");
    chk_pdown_all_off: assert property (
        wake_detect_on |-> !regulator_on && !receiver_on && !bus_pullup_on)
        else $error("power-down leak");
    chk_drive_follows_tx: assert property (
        bus_line_oe |-> bus_pullup_on && !$past(tx_data, 3))
        else $error("drive vs tx");
    chk_fault_holds_tx: assert property (
        internal_fault [*4] ##0 (up_reg == 3'h7)
        |-> fault_tx_enable_oe && !bus_line_oe)
        else $error("fault drive");
    chk_reg_bad_quiet: assert property (
        !regulator_good [*4] ##0 (up_reg == 3'h7)
        |-> reset_oe && !bus_line_oe)
        else $error("regulator drive");
    chk_supply_low_por: assert property (
        !battery_supply_above_off [*4] ##0 (up_reg == 3'h7)
        |-> reset_oe && !regulator_on && !receiver_on)
        else $error("supply reset");
    chk_rx_follows_bus: assert property (
        receiver_on [*3] |-> rx_data == $past(bus_line_in, 3))
        else $error("rx vs bus");
    chk_enter_oper: assert property (
        $rose(bus_pullup_on) |-> $past(regulator_good, 3)
        && $past(select_local_wake, 3) && $past(tx_data, 3)
        && $past(fault_tx_enable_in, 3) && !$past(internal_fault, 3))
        else $error("oper entry");
    chk_leave_oper: assert property (
        $fell(bus_pullup_on) && $past(battery_supply_above_off, 3)
        |-> wake_detect_on == !$past(select_local_wake, 3))
        else $error("oper exit");
    chk_one_wait: assert property (
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus wait");
endmodule : lin_mode_chk

bind lin_transceiver_mode_control lin_mode_chk u_chk (.*);

//--- test/lin_bus_node.sv
// far-side lin node: pulled-up wired-and bus, timed lows
// assumes one-cycle break_start pulses with break_len
`timescale 1ns/10ps
module lin_bus_node
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // bench command
    input  wire logic       break_start,
    input  wire logic [7:0] break_len,
    // device side of the wire
    input  wire logic       bus_line_oe,
    output logic            bus_line_in,
    output logic            bus_below_wake
);
    logic [7:0] low_reg;
    logic [7:0] low_next;

    // dominant hold counter
    always_comb
    begin
        low_next = (low_reg != 8'h00) ? low_reg - 8'h01 : 8'h00;
        if (break_start)
            low_next = break_len;
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            low_reg <= 8'h00;
        else
            low_reg <= low_next;
    end

    // pull-up: recessive unless driven
    assign bus_line_in    = !(bus_line_oe || (low_reg != 8'h00));
    assign bus_below_wake = !bus_line_in; // same wire, own threshold
endmodule : lin_bus_node

//--- test/test_lin_transceiver_mode_control.sv
// self-checking lin mode controller bench
// assumes lin_bus_node as far side
`timescale 1ns/10ps
module test_lin_transceiver_mode_control
    import lin_mode_pkg::*;
;
    localparam int WAKE_SIM = 20;
    logic              core_clk, rst_b, battery_supply_above_off;
    logic              battery_supply_above_on, regulator_good;
    logic              internal_fault, select_local_wake, host_pulls_low;
    logic              fault_tx_enable_in, fault_tx_enable_oe, tx_data;
    logic              rx_data, reset_oe, bus_line_in, bus_below_wake;
    logic              bus_line_oe, bus_pullup_on, wake_detect_on;
    logic              regulator_on, regulator_low_power, receiver_on;
    logic              window_watchdog_on, read, write, waitrequest;
    logic              break_start;
    logic [7:0]        break_len;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata, readdata;
    int                errors, samples_checked, cycles;

    // open-drain enable pin: host releases, device fault pulls low
    assign fault_tx_enable_in = !host_pulls_low && !fault_tx_enable_oe;

    lin_transceiver_mode_control #(.WAKE_CYCLES(WAKE_SIM)) dut (.core_clk,
        .rst_b, .clk_en(1'b1), .battery_supply_above_off,
        .battery_supply_above_on, .regulator_good, .internal_fault,
        .select_local_wake, .fault_tx_enable_in, .fault_tx_enable_out(),
        .fault_tx_enable_oe, .tx_data, .rx_data, .reset_out(), .reset_oe,
        .bus_line_in, .bus_below_wake, .bus_line_out(), .bus_line_oe,
        .bus_pullup_on, .wake_detect_on, .regulator_on, .regulator_low_power,
        .receiver_on, .window_watchdog_on, .address, .read, .write,
        .byteenable(4'hF), .writedata, .readdata, .waitrequest);
    lin_bus_node node (.core_clk, .rst_b, .break_start, .break_len,
        .bus_line_oe, .bus_line_in, .bus_below_wake);

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic compare(input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : compare
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : settle
    // request held until waitrequest is sampled low
    task automatic bus_cycle(input logic wr, input logic [3:0] adr,
                             input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        read      <= !wr;
        write     <= wr;
        address   <= adr;
        writedata <= wd;
        do
            @(posedge core_clk);
        while (waitrequest !== 1'b0);
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus_cycle
    // mode field and power outputs vs mode table
    task automatic check_mode(input mode_t m);
        logic [31:0] rd;
        logic        on;
        bus_cycle(1'b0, STATUS_OFS, 32'h0, rd);
        on = m inside {MODE_READY, MODE_OPER, MODE_TXOFF};
        compare(32'(m), 32'(rd[4:0]));
        compare({m == MODE_OPER, m == MODE_OPER, m == MODE_PDOWN, on, on,
            on && m != MODE_OPER}, {bus_pullup_on, window_watchdog_on,
            wake_detect_on, regulator_on, receiver_on, regulator_low_power});
    endtask : check_mode
    task automatic send_break(input logic [7:0] n);
        break_len   <= n;
        break_start <= 1'b1;
        @(posedge core_clk);
        break_start <= 1'b0;
        settle(int'(n) + 10);
    endtask : send_break

    ////////////////////////////////////////////////////////////////////////
    task automatic t_power_up;
        logic [31:0] rd;
        bus_cycle(1'b0, CTRL_OFS, 32'h0, rd);
        compare(32'(CTRL_RESET), rd);
        bus_cycle(1'b0, 4'h8, 32'h0, rd);
        compare(32'h0, rd);
        check_mode(MODE_POR);
        compare(32'h1, 32'(reset_oe));
        battery_supply_above_off <= 1'b1;
        settle(6);
        check_mode(MODE_POR);
        battery_supply_above_on <= 1'b1;
        settle(6);
        check_mode(MODE_READY);
    endtask : t_power_up
    task automatic t_operate;
        select_local_wake <= 1'b1;
        settle(8);
        check_mode(MODE_READY);
        regulator_good <= 1'b1;
        settle(8);
        check_mode(MODE_READY);
        tx_data <= 1'b1;
        settle(8);
        check_mode(MODE_OPER);
        tx_data <= 1'b0;
        settle(8);
        compare(32'h1, 32'(bus_line_oe));
        compare(32'h0, 32'(rx_data));
        regulator_good <= 1'b0;
        settle(8);
        compare(32'h0, 32'(bus_line_oe));
        compare(32'h1, 32'(reset_oe));
        regulator_good <= 1'b1;
        tx_data        <= 1'b1;
        settle(8);
        compare(32'h1, 32'(rx_data));
    endtask : t_operate
    task automatic t_tx_off;
        host_pulls_low <= 1'b1;
        settle(8);
        check_mode(MODE_TXOFF);
        internal_fault <= 1'b1;
        host_pulls_low <= 1'b0;
        tx_data        <= 1'b0;
        settle(8);
        check_mode(MODE_TXOFF);
        compare(32'h1, 32'(fault_tx_enable_oe));
        compare(32'h0, 32'(bus_line_oe));
        internal_fault <= 1'b0;
        tx_data        <= 1'b1;
        settle(8);
        check_mode(MODE_OPER);
    endtask : t_tx_off
    task automatic t_local_wake;
        select_local_wake <= 1'b0;
        settle(8);
        check_mode(MODE_PDOWN);
        select_local_wake <= 1'b1;
        settle(12);
        check_mode(MODE_OPER);
    endtask : t_local_wake
    // enable bit gates the bus wake; a short low is not a wake
    task automatic t_remote_wake;
        logic [31:0] rd;
        select_local_wake <= 1'b0;
        settle(8);
        regulator_good <= 1'b0;
        bus_cycle(1'b1, CTRL_OFS, 32'h2, rd);
        send_break(8'(WAKE_SIM + 2));
        check_mode(MODE_PDOWN);
        bus_cycle(1'b1, CTRL_OFS, 32'h3, rd);
        send_break(8'(WAKE_SIM - 2));
        check_mode(MODE_PDOWN);
        send_break(8'(WAKE_SIM + 2));
        check_mode(MODE_READY);
        bus_cycle(1'b0, STATUS_OFS, 32'h0, rd);
        compare(32'h3, 32'(rd[STAT_FAULT_BIT:STAT_RWAKE_BIT]));
        regulator_good <= 1'b1;
        bus_cycle(1'b1, STATUS_OFS, 32'h20, rd);
        bus_cycle(1'b0, STATUS_OFS, 32'h0, rd);
        compare(32'h6, 32'(rd[STAT_FAULT_BIT:STAT_RWAKE_BIT]));
        check_mode(MODE_READY);
        battery_supply_above_off <= 1'b0;
        battery_supply_above_on  <= 1'b0;
        settle(6);
        check_mode(MODE_POR);
    endtask : t_remote_wake

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // hang guard; run needs a few hundred cycles
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            report_and_stop;
        end
    end
    initial
    begin
        {rst_b, battery_supply_above_off, battery_supply_above_on} = 3'h0;
        {regulator_good, internal_fault, select_local_wake} = 3'h0;
        {host_pulls_low, tx_data, read, write, break_start} = 5'h0;
        {break_len, address, writedata} = '0;
        {errors, samples_checked, cycles} = '0;
        settle(16);
        rst_b <= 1'b1;
        t_power_up;
        t_operate;
        t_tx_off;
        t_local_wake;
        t_remote_wake;
        report_and_stop;
    end
endmodule : test_lin_transceiver_mode_control
